//--- wmct_pkg.sv
package wmct_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned AC_NUM = 4;
   localparam int unsigned AC_W = 2;
   localparam int unsigned IFS_W = 12;
   localparam int unsigned BO_W = 10;
   localparam int unsigned TSF_W = 64;
   localparam int unsigned NAV_W = 16;
   localparam int unsigned SLEEP_W = 32;
   localparam int unsigned OFS_NUM = 2;
   localparam int unsigned US_NS = 1000;
   localparam int unsigned CLK_NS = 10;
   // Microsecond tick for TSF and NAV
   localparam int unsigned US_CYC = US_NS / CLK_NS;
   localparam logic [7:0] US_CNT_MAX = 8'(US_CYC - 1);
   localparam logic [TSF_W-1:0] TSF_ONE = 64'h1;
   localparam logic [NAV_W-1:0] NAV_ZERO = 16'h0;
   localparam logic [BO_W-1:0] BO_ZERO = 10'h0;
   localparam logic [IFS_W-1:0] IFS_ZERO = 12'h0;
   localparam logic [SLEEP_W-1:0] SLEEP_ZERO = 32'h0;
   // Winner policy codes
   localparam logic [1:0] POL_HIGH_FIRST = 2'h0;
   localparam logic [1:0] POL_LOW_FIRST = 2'h1;
   localparam logic [1:0] POL_ROUND_ROBIN = 2'h2;
   typedef enum logic [1:0] {WMCT_IFS_IDLE, WMCT_IFS_COUNT, WMCT_IFS_DONE} wmct_ifs_t;
   typedef enum logic [1:0] {WMCT_PWR_RUN, WMCT_PWR_SLEEP, WMCT_PWR_WAKE} wmct_pwr_t;
endpackage

//--- wmct_timing.sv
// Function
// R1 - Interframe-space timers start counting when the PHY reports the medium went idle.
// R2 - The interframe-space trigger tells the transmit engine when to send a response or burst frame.
// R3 - Each access category has its own back-off engine that decrements per idle slot or pauses.
// R4 - A back-off counter reaching zero notifies the transmit engine for that category.
// R5 - Simultaneous zero back-offs are resolved by a sequencer-programmed policy.
// R6 - In power save the MAC clock is stopped while a sequencer-loaded slow-clock timer runs.
// R7 - On sleep timer expiry the block returns the MAC to normal operation.
// R8 - After waking the sequencer advances the TSF by the slept time.
// R9 - The sequencer can load the TSF timer from a received timestamp.
// R10 - The block tracks the target beacon transmission time beside the TSF.
// R11 - Trigger pulses are raised when the TSF reaches programmed offsets.
// R12 - The sequencer updates the NAV timer from a received duration field.
// R13 - NAV state feeds the interframe-space unit as virtual carrier sense.
// R14 - Channel-access state is given to the sequencer and transmission starts on the trigger.
// R15 - The NAV counts down to zero and reports virtual busy while nonzero.
module wmct_timing
   import wmct_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic slow_tick_i,
   input wire logic phy_busy_i,
   input wire logic slot_tick_i,
   input wire logic [IFS_W-1:0] ifs_len_i,
   input wire logic bo_load_i,
   input wire logic [AC_W-1:0] bo_ac_i,
   input wire logic [BO_W-1:0] bo_val_i,
   input wire logic [1:0] bo_policy_i,
   input wire logic tx_grant_i,
   input wire logic sleep_load_i,
   input wire logic [SLEEP_W-1:0] sleep_val_i,
   input wire logic tsf_load_i,
   input wire logic [TSF_W-1:0] tsf_val_i,
   input wire logic tbtt_load_i,
   input wire logic [TSF_W-1:0] tbtt_val_i,
   input wire logic ofs_load_i,
   input wire logic ofs_sel_i,
   input wire logic [TSF_W-1:0] ofs_val_i,
   input wire logic nav_load_i,
   input wire logic [NAV_W-1:0] nav_val_i,
   output logic ifs_trig_o,
   output logic medium_idle_o,
   output logic [AC_NUM-1:0] bo_zero_o,
   output logic tx_start_o,
   output logic [AC_W-1:0] tx_ac_o,
   output logic mac_clk_en_o,
   output logic sleep_active_o,
   output logic wake_o,
   output logic [TSF_W-1:0] tsf_o,
   output logic tbtt_o,
   output logic [OFS_NUM-1:0] ofs_trig_o,
   output logic nav_busy_o,
   output logic [NAV_W-1:0] nav_o
);
   logic [7:0] us_cnt, next_us_cnt;
   logic us_tick;
   wmct_ifs_t ifs_st, next_ifs_st;
   logic [IFS_W-1:0] ifs_cnt, next_ifs_cnt;
   logic [BO_W-1:0] bo_cnt [AC_NUM];
   logic [BO_W-1:0] next_bo_cnt [AC_NUM];
   logic [AC_NUM-1:0] bo_armed, next_bo_armed;
   logic [AC_W-1:0] rr_last, next_rr_last;
   logic [AC_W-1:0] next_tx_ac;
   logic next_tx_start;
   logic [AC_NUM-1:0] next_bo_zero;
   wmct_pwr_t pwr_st, next_pwr_st;
   logic [SLEEP_W-1:0] sleep_cnt, next_sleep_cnt;
   logic [TSF_W-1:0] tsf, next_tsf;
   logic [TSF_W-1:0] tbtt, next_tbtt;
   logic [TSF_W-1:0] ofs [OFS_NUM];
   logic [TSF_W-1:0] next_ofs [OFS_NUM];
   logic [OFS_NUM-1:0] next_ofs_trig;
   logic next_tbtt_o;
   logic [NAV_W-1:0] nav, next_nav;
   logic idle_all;

   function automatic logic [AC_W-1:0] wmct_pick(input logic [AC_NUM-1:0] req,
         input logic [1:0] pol, input logic [AC_W-1:0] last);
      logic [AC_W-1:0] w;
      logic [AC_W-1:0] idx;
      w = '0;
      if (pol == POL_LOW_FIRST) begin
         for (int i = AC_NUM - 1; i >= 0; i--) begin
            if (req[i]) w = AC_W'(i);
         end
      end else if (pol == POL_ROUND_ROBIN) begin
         for (int i = AC_NUM; i >= 1; i--) begin
            idx = AC_W'(int'(last) + i);
            if (req[idx]) w = idx;
         end
      end else begin
         for (int i = 0; i < AC_NUM; i++) begin
            if (req[i]) w = AC_W'(i);
         end
      end
      return w;
   endfunction

   assign us_tick = (us_cnt == US_CNT_MAX);
   assign idle_all = !phy_busy_i && (nav == NAV_ZERO); // R13
   assign medium_idle_o = (ifs_st == WMCT_IFS_DONE); // R14
   assign nav_busy_o = (nav != NAV_ZERO); // R15
   assign nav_o = nav;
   assign tsf_o = tsf;
   assign mac_clk_en_o = (pwr_st != WMCT_PWR_SLEEP); // R6
   assign sleep_active_o = (pwr_st == WMCT_PWR_SLEEP);

   always_comb begin
      next_us_cnt = us_tick ? 8'h0 : us_cnt + 8'h1;
      next_ifs_st = ifs_st;
      next_ifs_cnt = ifs_cnt;
      case (ifs_st)
         WMCT_IFS_IDLE: begin
            if (idle_all) begin
               next_ifs_st = WMCT_IFS_COUNT; // R1
               next_ifs_cnt = ifs_len_i;
            end
         end
         WMCT_IFS_COUNT: begin
            if (!idle_all) begin
               next_ifs_st = WMCT_IFS_IDLE;
            end else if (ifs_cnt == IFS_ZERO) begin
               next_ifs_st = WMCT_IFS_DONE;
            end else begin
               next_ifs_cnt = ifs_cnt - 12'h1;
            end
         end
         WMCT_IFS_DONE: begin
            if (!idle_all) next_ifs_st = WMCT_IFS_IDLE;
         end
         default: next_ifs_st = WMCT_IFS_IDLE;
      endcase
   end

   always_comb begin
      next_bo_armed = bo_armed;
      next_rr_last = rr_last;
      next_tx_start = 1'b0;
      next_tx_ac = tx_ac_o;
      for (int a = 0; a < AC_NUM; a++) begin
         next_bo_cnt[a] = bo_cnt[a];
         next_bo_zero[a] = bo_armed[a] && (bo_cnt[a] == BO_ZERO) && medium_idle_o; // R4
         if (bo_armed[a] && medium_idle_o && slot_tick_i && bo_cnt[a] != BO_ZERO) begin
            next_bo_cnt[a] = bo_cnt[a] - 10'h1; // R3
         end
      end
      if (|next_bo_zero && !tx_start_o) begin
         next_tx_start = 1'b1; // R2
         next_tx_ac = wmct_pick(next_bo_zero, bo_policy_i, rr_last); // R5
         next_rr_last = next_tx_ac;
      end
      if (tx_grant_i) next_bo_armed[tx_ac_o] = 1'b0;
      if (bo_load_i) begin
         next_bo_cnt[bo_ac_i] = bo_val_i;
         next_bo_armed[bo_ac_i] = 1'b1;
      end
   end

   always_comb begin
      next_pwr_st = pwr_st;
      next_sleep_cnt = sleep_cnt;
      case (pwr_st)
         WMCT_PWR_RUN: begin
            if (sleep_load_i && sleep_val_i != SLEEP_ZERO) begin
               next_pwr_st = WMCT_PWR_SLEEP;
               next_sleep_cnt = sleep_val_i;
            end
         end
         WMCT_PWR_SLEEP: begin
            if (slow_tick_i) begin
               if (sleep_cnt == 32'h1) next_pwr_st = WMCT_PWR_WAKE; // R7
               next_sleep_cnt = sleep_cnt - 32'h1;
            end
         end
         WMCT_PWR_WAKE: next_pwr_st = WMCT_PWR_RUN;
         default: next_pwr_st = WMCT_PWR_RUN;
      endcase
   end

   always_comb begin
      next_tsf = tsf;
      if (tsf_load_i) begin
         next_tsf = tsf_val_i; // R9
      end else if (us_tick && pwr_st != WMCT_PWR_SLEEP) begin
         next_tsf = tsf + TSF_ONE;
      end
      next_tbtt = tbtt_load_i ? tbtt_val_i : tbtt; // R10
      next_tbtt_o = (tsf == tbtt) && us_tick;
      for (int k = 0; k < OFS_NUM; k++) begin
         next_ofs[k] = ofs[k];
         next_ofs_trig[k] = (tsf == ofs[k]) && us_tick; // R11
      end
      if (ofs_load_i) next_ofs[ofs_sel_i] = ofs_val_i;
      next_nav = nav;
      if (nav_load_i && nav_val_i > nav) begin
         next_nav = nav_val_i; // R12
      end else if (us_tick && nav != NAV_ZERO) begin
         next_nav = nav - 16'h1; // R15
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         us_cnt <= 8'h0;
         ifs_st <= WMCT_IFS_IDLE;
         ifs_cnt <= IFS_ZERO;
         bo_armed <= '0;
         rr_last <= '0;
         tx_start_o <= 1'b0;
         tx_ac_o <= '0;
         bo_zero_o <= '0;
         pwr_st <= WMCT_PWR_RUN;
         sleep_cnt <= SLEEP_ZERO;
         tsf <= '0;
         tbtt <= '0;
         tbtt_o <= 1'b0;
         ofs_trig_o <= '0;
         nav <= NAV_ZERO;
         for (int a = 0; a < AC_NUM; a++) bo_cnt[a] <= BO_ZERO;
         for (int k = 0; k < OFS_NUM; k++) ofs[k] <= '0;
      end else begin
         us_cnt <= next_us_cnt;
         ifs_st <= next_ifs_st;
         ifs_cnt <= next_ifs_cnt;
         bo_armed <= next_bo_armed;
         rr_last <= next_rr_last;
         tx_start_o <= next_tx_start;
         tx_ac_o <= next_tx_ac;
         bo_zero_o <= next_bo_zero;
         pwr_st <= next_pwr_st;
         sleep_cnt <= next_sleep_cnt;
         tsf <= next_tsf;
         tbtt <= next_tbtt;
         tbtt_o <= next_tbtt_o;
         ofs_trig_o <= next_ofs_trig;
         nav <= next_nav;
         bo_cnt <= next_bo_cnt;
         ofs <= next_ofs;
      end
   end

   assign ifs_trig_o = (ifs_st == WMCT_IFS_COUNT) && idle_all && (ifs_cnt == IFS_ZERO); // R2
   assign wake_o = (pwr_st == WMCT_PWR_WAKE); // R7

   chk_ifs_starts: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
      (ifs_st == WMCT_IFS_IDLE && !phy_busy_i && nav == NAV_ZERO) |=> ifs_st == WMCT_IFS_COUNT)
      else $error("ifs timer did not start on idle medium");
   chk_ifs_trig: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
      ifs_trig_o |=> medium_idle_o)
      else $error("ifs trigger not followed by idle state");
   chk_bo_pause: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
      (!medium_idle_o && !bo_load_i) |=> bo_cnt[0] == $past(bo_cnt[0]))
      else $error("backoff decremented while medium busy");
   chk_bo_notify: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
      (bo_armed[0] && bo_cnt[0] == BO_ZERO && medium_idle_o && !tx_start_o) |=> tx_start_o)
      else $error("zero backoff did not notify transmit engine");
   chk_winner_ok: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
      tx_start_o |-> bo_zero_o[tx_ac_o] && ($past(bo_policy_i) != POL_LOW_FIRST ||
         (bo_zero_o & ((4'h1 << tx_ac_o) - 4'h1)) == 4'h0))
      else $error("winner is not a zero backoff category");
   chk_sleep_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
      (pwr_st == WMCT_PWR_RUN && sleep_load_i && sleep_val_i != SLEEP_ZERO) |=> !mac_clk_en_o)
      else $error("mac clock not stopped on sleep");
   chk_wake_up: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
      wake_o |=> mac_clk_en_o && pwr_st == WMCT_PWR_RUN)
      else $error("mac not restored after wake");
   chk_tsf_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
      tsf_load_i |=> tsf_o == $past(tsf_val_i))
      else $error("tsf load lost");
   chk_nav_busy: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R15
      (nav_load_i && nav_val_i != NAV_ZERO) |=> nav_busy_o ##1 !medium_idle_o)
      else $error("nav not reported busy");
endmodule

//--- wmct_seq_model.sv
module wmct_seq_model
   import wmct_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic busy_cmd_i,
   input wire logic tx_start_i,
   input wire logic wake_i,
   input wire logic [TSF_W-1:0] tsf_i,
   input wire logic [TSF_W-1:0] slept_i,
   output logic phy_busy_o,
   output logic slot_tick_o,
   output logic slow_tick_o,
   output logic tx_grant_o,
   output logic tsf_load_o,
   output logic [TSF_W-1:0] tsf_val_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] div;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div <= 4'h0;
         {phy_busy_o, slot_tick_o, slow_tick_o, tx_grant_o, tsf_load_o} <= 5'h0;
         tsf_val_o <= 64'h0;
      end else begin
         div <= div + 4'h1;
         phy_busy_o <= busy_cmd_i;
         slot_tick_o <= div[2:0] == 3'h7;
         slow_tick_o <= div == 4'hf;
         // Every start is granted one cycle later; after wake the slept time is added back
         tx_grant_o <= tx_start_i;
         tsf_load_o <= wake_i;
         tsf_val_o <= tsf_i + slept_i;
      end
   end
endmodule

//--- wmct_timing_test.sv
module wmct_timing_test
   import wmct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [3:0] m; logic [1:0] p; logic [1:0] w;} wmct_row_t;
   wmct_row_t rows [4] = '{'{4'hf, POL_HIGH_FIRST, 2'h3}, '{4'h6, POL_LOW_FIRST, 2'h1},
      '{4'hf, POL_LOW_FIRST, 2'h0}, '{4'ha, POL_ROUND_ROBIN, 2'h1}};
   logic clk_i, rst_b_i, busy_cmd, bo_load_i, sleep_load_i, tsf_ld, tbtt_load_i, ofs_load_i;
   logic ofs_sel_i, nav_load_i, phy_busy_i, slot_tick_i, slow_tick_i, tx_grant_i, m_ld;
   logic ifs_trig_o, medium_idle_o, tx_start_o, mac_clk_en_o, sleep_active_o, wake_o, tbtt_o;
   logic nav_busy_o;
   logic [1:0] bo_ac_i, bo_policy_i, tx_ac_o, ofs_trig_o;
   logic [3:0] bo_zero_o;
   logic [5:0] ev;
   logic [BO_W-1:0] bo_val_i;
   logic [SLEEP_W-1:0] sleep_val_i;
   logic [TSF_W-1:0] tsf_val_i, tbtt_val_i, ofs_val_i, m_val, tsf_o, pre, e;
   logic [NAV_W-1:0] nav_val_i, nav_o;
   int n_errors = 0, check_count = 0, cyc = 0, n;
   assign ev = {wake_o, tbtt_o, ofs_trig_o, ifs_trig_o, tx_start_o};
   wmct_timing dut_u (.clk_i, .rst_b_i, .slow_tick_i, .phy_busy_i, .slot_tick_i, .ifs_len_i(12'h14),
      .bo_load_i, .bo_ac_i, .bo_val_i, .bo_policy_i, .tx_grant_i, .sleep_load_i, .sleep_val_i,
      .tsf_load_i(tsf_ld | m_ld), .tsf_val_i(m_ld ? m_val : tsf_val_i), .tbtt_load_i, .tbtt_val_i,
      .ofs_load_i, .ofs_sel_i, .ofs_val_i, .nav_load_i, .nav_val_i, .ifs_trig_o, .medium_idle_o,
      .bo_zero_o, .tx_start_o, .tx_ac_o, .mac_clk_en_o, .sleep_active_o, .wake_o, .tsf_o,
      .tbtt_o, .ofs_trig_o, .nav_busy_o, .nav_o);
   wmct_seq_model model_u (.clk_i, .rst_b_i, .busy_cmd_i(busy_cmd), .tx_start_i(tx_start_o),
      .wake_i(wake_o), .tsf_i(tsf_o), .slept_i(64'h40), .phy_busy_o(phy_busy_i),
      .slot_tick_o(slot_tick_i), .slow_tick_o(slow_tick_i), .tx_grant_o(tx_grant_i),
      .tsf_load_o(m_ld), .tsf_val_o(m_val));
   task automatic chk(input logic ok, input string s);
      check_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, s);
      end
   endtask
   // Waits on one event bit, leaving the count of cycles in n
   task automatic wt(input int b, input int lim);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ev[b] !== 1'b1 && n < lim);
   endtask
   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      {rst_b_i, bo_load_i, sleep_load_i, tsf_ld, tbtt_load_i, ofs_load_i, ofs_sel_i} = '0;
      {nav_load_i, bo_ac_i, bo_policy_i, bo_val_i, sleep_val_i, nav_val_i} = '0;
      {tsf_val_i, tbtt_val_i, ofs_val_i} = '0;
      busy_cmd = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
      chk(mac_clk_en_o === 1 && tsf_o === 0 && tx_start_o === 0 && nav_o === 0, "reset");
      foreach (rows[i]) begin
         @(posedge clk_i);
         bo_policy_i <= rows[i].p;
         for (int a = 0; a < 4; a++) begin
            if (rows[i].m[a]) begin
               @(posedge clk_i);
               bo_load_i <= 1'b1;
               bo_ac_i <= 2'(a);
               bo_val_i <= 10'h2;
            end
         end
         @(posedge clk_i);
         bo_load_i <= 1'b0;
         busy_cmd <= 1'b0;
         wt(0, 400);
         chk(n < 400 && tx_ac_o === rows[i].w, "winner");
         chk(bo_zero_o === rows[i].m, "zero flags");
         repeat (60) @(posedge clk_i);
         busy_cmd <= 1'b1;
      end
      @(posedge clk_i);
      busy_cmd <= 1'b0;
      wt(1, 100);
      chk(n >= 18 && n <= 26, "ifs length");
      repeat (3) @(negedge clk_i);
      chk(medium_idle_o === 1, "idle");
      @(posedge clk_i);
      busy_cmd <= 1'b1;
      nav_load_i <= 1'b1;
      nav_val_i <= 16'h5;
      @(posedge clk_i);
      nav_val_i <= 16'h3;
      @(posedge clk_i);
      nav_load_i <= 1'b0;
      busy_cmd <= 1'b0;
      @(negedge clk_i);
      chk(nav_o[2] === 1 && nav_busy_o === 1, "nav load");
      wt(1, 150);
      chk(n == 150 && medium_idle_o === 0, "nav blocks");
      wt(1, 600);
      chk(n < 600 && nav_o === 0 && nav_busy_o === 0, "nav end");
      @(posedge clk_i);
      {tsf_ld, tbtt_load_i, ofs_load_i} <= 3'h7;
      tsf_val_i <= 64'h100;
      tbtt_val_i <= 64'h105;
      ofs_val_i <= 64'h103;
      @(posedge clk_i);
      {tsf_ld, tbtt_load_i, ofs_sel_i} <= 3'h1;
      ofs_val_i <= 64'h107;
      @(posedge clk_i);
      ofs_load_i <= 1'b0;
      @(negedge clk_i);
      chk(tsf_o >= 64'h100 && tsf_o <= 64'h101, "tsf load");
      for (int k = 0; k < 3; k++) begin
         e = 64'h103 + 64'(2 * k);
         wt(k == 2 ? 3 : 2 + 2 * k, 900);
         chk(n < 900 && tsf_o >= e && tsf_o <= e + 1, "tsf event");
      end
      @(posedge clk_i);
      sleep_load_i <= 1'b1;
      @(posedge clk_i);
      sleep_load_i <= 1'b0;
      @(negedge clk_i);
      chk(sleep_active_o === 0, "zero sleep");
      pre = tsf_o;
      @(posedge clk_i);
      sleep_load_i <= 1'b1;
      sleep_val_i <= 32'h4;
      @(posedge clk_i);
      sleep_load_i <= 1'b0;
      @(negedge clk_i);
      chk(sleep_active_o === 1 && mac_clk_en_o === 0, "sleep");
      wt(5, 200);
      chk(n < 200, "wake");
      repeat (3) @(negedge clk_i);
      chk(mac_clk_en_o === 1 && sleep_active_o === 0, "run");
      chk(tsf_o >= pre + 64 && tsf_o <= pre + 66, "tsf catch up");
      @(posedge clk_i);
      sleep_load_i <= 1'b1;
      @(posedge clk_i);
      sleep_load_i <= 1'b0;
      rst_b_i <= 1'b0;
      @(negedge clk_i);
      chk(sleep_active_o === 0 && mac_clk_en_o === 1 && tsf_o === 0, "reset in sleep");
      give_verdict();
   end
endmodule
